// ### bst_pkg.sv
// Constants, types and state codes for the boundary scan test access port.
// Assumes the test port logic and the system-clock logic both import it.
package bst_pkg;

    // Boundary scan register length and instruction width
    localparam int BST_BSR_LEN = 62;
    localparam int BST_IR_LEN = 4;

    // Instruction codes
    localparam logic [3:0] BST_IR_BYPASS = 4'hf;
    localparam logic [3:0] BST_IR_SAMPLE = 4'h2;
    localparam logic [3:0] BST_IR_EXTEST = 4'h0;
    localparam logic [3:0] BST_IR_HIGHZ = 4'h9;
    localparam logic [3:0] BST_IR_CLAMP = 4'hc;

    // Values after reset and fixed capture patterns
    localparam logic [3:0] BST_IR_RESET = BST_IR_BYPASS;
    localparam logic [3:0] BST_IR_CAPTURE = 4'h1;
    localparam logic BST_BYP_CAPTURE = 1'b0;
    localparam logic [61:0] BST_BSR_RESET = 62'h0;

    // Cells that drive their pin while extest or clamp owns the pins:
    // indices 1..3 (match status outputs), 4..19 and 22..37 (match bus),
    // 38..53 (control data bus). Index 0 is bit 1, the first out on TDO.
    localparam logic [61:0] BST_DRIVE_MASK = 62'h3fffffffcffffe;

    // Synchroniser depth
    localparam int BST_SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bst_tap_state_t;

    // Decoded instruction
    typedef struct packed {
        logic sel_bsr;
        logic drive_test;
        logic highz;
        logic sample_run;
    } bst_instr_t;

    // Pin ring as seen by the pads
    typedef struct packed {
        logic [61:0] val;
        logic [61:0] oe;
    } bst_pins_t;

endpackage : bst_pkg

// ### bst_sync2.sv
// Two-flop level synchroniser of selectable width.
// Assumes an asynchronous active-high reset belonging to the destination clock.
`timescale 1ns/1ps
module bst_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;

endmodule : bst_sync2

// ### bst_boundary_scan_tap.sv
// Test access port: serial controller, instruction, bypass and boundary
// scan registers, and the pad multiplexers of the functional pin ring.
// Assumes TMS and TDI come from the test master on TCK and have pad
// pull-ups, and that the system core supplies its own pin values.
// The core reads o_sys_test_mode on its own clock.
`timescale 1ns/1ps
module bst_boundary_scan_tap
    import bst_pkg::*;
(
    // System clock domain
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Test link
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    // Pin ring
    input wire logic [61:0] i_pin_in,
    input wire logic [61:0] i_core_out,
    input wire logic [61:0] i_core_oe,
    output logic [61:0] o_pin_out,
    output logic [61:0] o_pin_oe,
    // Status toward the system core
    output logic o_sys_test_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode

    function automatic bst_instr_t decode_instr(input logic [3:0] code);
        bst_instr_t d;
        d = '0;
        unique case (code)
            BST_IR_SAMPLE: begin
                d.sel_bsr = 1'b1;
            end
            BST_IR_EXTEST: begin
                d.sel_bsr = 1'b1;
                d.drive_test = 1'b1;
                d.sample_run = 1'b1;
            end
            BST_IR_HIGHZ: begin
                d.highz = 1'b1;
            end
            BST_IR_CLAMP: begin
                d.drive_test = 1'b1;
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction : decode_instr

    // Either shift state; TDO is live only there
    function automatic logic is_shift(input bst_tap_state_t s);
        return (s == ST_SHIFT_IR) || (s == ST_SHIFT_DR);
    endfunction : is_shift

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic tck_rst;
    bst_tap_state_t state_q;
    bst_tap_state_t state_d;
    logic [3:0] ir_shift_q;
    logic [3:0] ir_q;
    logic bypass_q;
    logic [61:0] bsr_q;
    logic [61:0] upd_q;
    logic [61:0] pin_sync;
    logic tdo_q;
    logic tdo_oe_q;
    logic serial_out;
    logic test_owns_pins;
    logic test_mode_sys;
    logic owns_q;
    logic enter_reset;
    bst_instr_t instr;
    bst_pins_t pins;

    // All test-port state except u_mode_sync, which resets from i_rst, resets only
    // from the test reset pin, so a test reset never disturbs the system logic.
    assign tck_rst = ~i_trst_n;
    assign instr = decode_instr(ir_q);

    // Bypass comes back on the very edge that enters Test-Logic-Reset, so
    // the pins return to the core while the controller waits there.
    assign enter_reset = (state_d == ST_RESET);

    ////////////////////////////////////////////////////////////////////////
    // Controller state machine

    // TMS arrives from the master on TCK itself, so it is used directly;
    // the pad pull-up makes an open pin read as one.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET: begin
                state_d = i_tms ? ST_RESET : ST_IDLE;
            end
            ST_IDLE: begin
                state_d = i_tms ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_DR: begin
                state_d = i_tms ? ST_SEL_IR : ST_CAP_DR;
            end
            ST_CAP_DR: begin
                state_d = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_SHIFT_DR: begin
                state_d = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_EXIT1_DR: begin
                state_d = i_tms ? ST_UPD_DR : ST_PAUSE_DR;
            end
            ST_PAUSE_DR: begin
                state_d = i_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            end
            ST_EXIT2_DR: begin
                state_d = i_tms ? ST_UPD_DR : ST_SHIFT_DR;
            end
            ST_UPD_DR: begin
                state_d = i_tms ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_IR: begin
                // From any state five TMS-high edges end here and then in reset
                state_d = i_tms ? ST_RESET : ST_CAP_IR;
            end
            ST_CAP_IR: begin
                state_d = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_SHIFT_IR: begin
                state_d = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_EXIT1_IR: begin
                state_d = i_tms ? ST_UPD_IR : ST_PAUSE_IR;
            end
            ST_PAUSE_IR: begin
                state_d = i_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            end
            ST_EXIT2_IR: begin
                state_d = i_tms ? ST_UPD_IR : ST_SHIFT_IR;
            end
            ST_UPD_IR: begin
                state_d = i_tms ? ST_SEL_DR : ST_IDLE;
            end
        endcase
    end

    // Test reset is asynchronous; TCK may be stopped while it is held
    always_ff @(posedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction register

    // The fixed capture pattern ends in 01 so a master can check the chain
    always_ff @(posedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            ir_shift_q <= BST_IR_RESET;
        end else if (state_q == ST_CAP_IR) begin
            ir_shift_q <= BST_IR_CAPTURE;
        end else if (state_q == ST_SHIFT_IR) begin
            ir_shift_q <= {i_tdi, ir_shift_q[3:1]};
        end
    end

    // The active code changes only at Update-IR or on entry to Test-Logic-Reset, never mid-shift
    always_ff @(posedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            ir_q <= BST_IR_RESET;
        end else if (enter_reset) begin
            ir_q <= BST_IR_RESET;
        end else if (state_q == ST_UPD_IR) begin
            ir_q <= ir_shift_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bypass register

    // Captures zero, so a master walking the chain can tell where each
    // one-bit path begins.
    always_ff @(posedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            bypass_q <= BST_BYP_CAPTURE;
        end else if (!instr.sel_bsr && state_q == ST_CAP_DR) begin
            bypass_q <= BST_BYP_CAPTURE;
        end else if (!instr.sel_bsr && state_q == ST_SHIFT_DR) begin
            bypass_q <= i_tdi;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boundary scan register

    // Pad values are asynchronous to TCK; the capture sees them two TCK
    // edges late, which a static board test does not notice.
    bst_sync2 #(
        .WIDTH(BST_BSR_LEN)
    ) u_pin_sync (
        .i_clk(i_tck),
        .i_rst(tck_rst),
        .i_d(i_pin_in),
        .o_q(pin_sync)
    );

    // One cell per functional pin, test pins excluded.
    // Under extest every Run-Test/Idle edge recaptures, but Capture-DR loads again, so the
    // next shift returns the pin values taken at Capture-DR.
    always_ff @(posedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            bsr_q <= BST_BSR_RESET;
        end else if (instr.sel_bsr && state_q == ST_CAP_DR) begin
            bsr_q <= pin_sync;
        end else if (instr.sel_bsr && state_q == ST_SHIFT_DR) begin
            // Index 0 leaves first; earlier contents stream out on TDO
            bsr_q <= {i_tdi, bsr_q[61:1]};
        end else if (instr.sample_run && state_q == ST_IDLE) begin
            bsr_q <= pin_sync;
        end
    end

    // Update stage: written only under sample/preload or extest, so it
    // holds still for as long as clamp is selected.
    always_ff @(posedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            upd_q <= BST_BSR_RESET;
        end else if (instr.sel_bsr && state_q == ST_UPD_DR) begin
            upd_q <= bsr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output

    always_comb begin
        if (state_q == ST_SHIFT_IR) begin
            serial_out = ir_shift_q[0];
        end else if (instr.sel_bsr) begin
            serial_out = bsr_q[0];
        end else begin
            serial_out = bypass_q;
        end
    end

    // TDO moves on the falling edge, giving the master, which samples on
    // the rising edge, half a period of setup.
    always_ff @(negedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= serial_out;
            tdo_oe_q <= is_shift(state_q);
        end
    end

    assign o_tdo = tdo_q;
    assign o_tdo_oe = tdo_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Pad multiplexers

    // Sample/preload and bypass leave the core in charge of every pin.
    // High-Z wins over a drive code; cells outside the drive mask are
    // input-only and the test logic never drives them.
    always_comb begin
        pins.val = i_core_out;
        pins.oe = i_core_oe;
        if (instr.highz) begin
            pins.oe = '0;
        end else if (instr.drive_test) begin
            pins.val = upd_q;
            pins.oe = BST_DRIVE_MASK;
        end
    end

    assign o_pin_out = pins.val;
    assign o_pin_oe = pins.oe;

    ////////////////////////////////////////////////////////////////////////
    // Crossing toward the system clock

    // The core learns that its pins are taken so it can stop relying on
    // them; the level passes two flops on the system clock.
    assign test_owns_pins = instr.drive_test | instr.highz;

    // A registered copy feeds the synchroniser: the decode of a four-bit
    // code may glitch while the code changes, and a glitch could be caught.
    // The falling edge is used because TCK may stop right after Update-IR,
    // and a rising-edge copy would then lag until the next frame.
    always_ff @(negedge i_tck or posedge tck_rst) begin
        if (tck_rst) begin
            owns_q <= 1'b0;
        end else begin
            owns_q <= test_owns_pins;
        end
    end

    bst_sync2 #(
        .WIDTH(1)
    ) u_mode_sync (
        .i_clk(i_clk_sys),
        .i_rst(i_rst),
        .i_d(owns_q),
        .o_q(test_mode_sys)
    );

    assign o_sys_test_mode = test_mode_sys;

endmodule : bst_boundary_scan_tap

// ### bst_tap_checker.sv
// Assertions on the test link pins and the pad ring.
// Assumes a bind to bst_boundary_scan_tap; TCK stands still between frames.
`timescale 1ns/1ps
module bst_tap_checker
    import bst_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic [61:0] i_core_out,
    input wire logic [61:0] i_core_oe,
    input wire logic [61:0] o_pin_out,
    input wire logic [61:0] o_pin_oe
);
    logic [1:0] rise_q;
    ////////////////////////////////
    sequence s_tlr;
        i_tms [*5];
    endsequence
    sequence s_ir;
        s_tlr ##1 !i_tms ##1 i_tms [*2] ##1 !i_tms [*2];
    endsequence
    sequence s_dr;
        s_tlr ##1 !i_tms ##1 i_tms ##1 !i_tms [*2];
    endsequence
    // TDO may move only on the falling edge, so it must still match the rising one
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            rise_q <= 2'b00;
        end else begin
            rise_q <= {o_tdo, o_tdo_oe};
        end
    end
    ////////////////////////////////
    AST_TRST: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_trst_n |-> !o_tdo_oe && o_pin_oe == i_core_oe) else $error("reset ignored");
    AST_TLR: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        s_tlr |=> !o_tdo_oe && o_pin_oe == i_core_oe) else $error("tms reset ignored");
    AST_SHIFT_IR: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        s_ir |=> o_tdo_oe && o_tdo) else $error("ir capture wrong");
    AST_SHIFT_DR: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        s_dr |=> o_tdo_oe && !o_tdo) else $error("bypass capture wrong");
    AST_BYP: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        s_dr ##1 !i_tms |=> o_tdo == $past(i_tdi)) else $error("bypass delay wrong");
    AST_TDO_EDGE: assert property (@(negedge i_tck) disable iff (!i_trst_n)
        {o_tdo, o_tdo_oe} == rise_q) else $error("tdo moved on rise");
    AST_TDO_OE: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        o_tdo_oe |=> o_tdo_oe == !$past(i_tms)) else $error("tdo enable wrong");
    AST_PINS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_pin_oe == i_core_oe) ? (o_pin_out == i_core_out)
        : (o_pin_oe == 62'h0 || o_pin_oe == BST_DRIVE_MASK)) else $error("pad mux wrong");
endmodule : bst_tap_checker

bind bst_boundary_scan_tap bst_tap_checker u_chk (.i_clk_sys, .i_rst, .i_tck, .i_trst_n,
    .i_tms, .i_tdi, .o_tdo, .o_tdo_oe, .i_core_out, .i_core_oe, .o_pin_out, .o_pin_oe);

// ### bst_test_master.sv
// Board-test master: clocks TCK only during its own steps.
// Assumes the bench calls step from one process at a time.
`timescale 1ns/1ps
module bst_test_master (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    // Starts at the pull-up level; between frames the pins keep the last step's values
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // One 160 ns TCK period; TDO is taken at the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #80;
        o_tck = 1'b1;
        tdo = i_tdo;
        #80;
        o_tck = 1'b0;
    endtask : step
endmodule : bst_test_master

// ### tb_boundary_scan_tap.sv
// Bench for the boundary scan test port, one task per scenario.
// Assumes the master drives the link and the checker is bound.
`timescale 1ns/1ps
module tb_boundary_scan_tap
    import bst_pkg::*;
;
    localparam logic [61:0] PV = 62'h3123456789abcdef;
    localparam logic [61:0] QV = 62'h123456789abcdef0;
    localparam logic [61:0] RV = 62'h3c3c3c3c3c3c3c3c;
    logic clk, rst, trst_n, tck, tms, tdi, tdo, tdo_oe, mode;
    logic [61:0] pin_in, core_out, core_oe, pin_out, pin_oe;
    logic [63:0] d;
    int fails = 0;
    int checks_done = 0;

    bst_boundary_scan_tap dut (.i_clk_sys(clk), .i_rst(rst), .i_tck(tck), .i_trst_n(trst_n),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_in(pin_in),
        .i_core_out(core_out), .i_core_oe(core_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
        .o_sys_test_mode(mode));
    // A released TDO reads as unknown
    bst_test_master master (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .i_tdo(tdo_oe ? tdo : 1'bx));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////
    task automatic cmp(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic go_idle();
        logic o;
        repeat (5) master.step(1'b1, 1'b1, o);
        master.step(1'b0, 1'b1, o);
    endtask : go_idle

    // Idle, Shift-IR for four bits, Update-IR, back to Idle
    task automatic load_ir(input logic [3:0] code);
        logic [9:0] t;
        logic [3:0] cap;
        logic o;
        t = 10'h183;
        for (int i = 0; i < 10; i++) begin
            master.step(t[i], (i > 3 && i < 8) ? code[i-4] : 1'b1, o);
            if (i > 3 && i < 8) cap[i-4] = o;
        end
        cmp("ir capture", 64'h1, 64'(cap));
    endtask : load_ir

    // TDI bit i goes in as TDO bit i comes out
    task automatic scan_dr(input logic [63:0] din, input int n);
        logic o;
        d = 64'h0;
        master.step(1'b1, 1'b1, o);
        master.step(1'b0, 1'b1, o);
        master.step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            master.step(i == n - 1, din[i], o);
            d[i] = o;
        end
        master.step(1'b1, 1'b1, o);
        master.step(1'b0, 1'b1, o);
    endtask : scan_dr

    task automatic chk_byp(input string nm);
        scan_dr(64'h1, 2);
        cmp(nm, 64'h2, d);
    endtask : chk_byp
    ////////////////////////////////
    task automatic t_sample();
        load_ir(BST_IR_SAMPLE);
        scan_dr({1'b0, QV, 1'b1}, 63);
        cmp("sampled ring", 64'(PV), 64'(d[61:0]));
        cmp("ring length", 64'h1, 64'(d[62]));
    endtask : t_sample

    task automatic t_extest();
        logic o;
        @(posedge clk);
        #1;
        pin_in = ~PV;
        load_ir(BST_IR_EXTEST);
        cmp("extest drive", 64'(QV), 64'(pin_out));
        cmp("extest oe", 64'(BST_DRIVE_MASK), 64'(pin_oe));
        master.step(1'b0, 1'b1, o);
        scan_dr(64'(RV), 62);
        cmp("extest sample", 64'({2'b00, ~PV}), d);
        cmp("extest update", 64'(RV), 64'(pin_out));
    endtask : t_extest

    task automatic t_clamp_highz();
        load_ir(BST_IR_CLAMP);
        chk_byp("clamp path");
        cmp("clamp hold", 64'(RV), 64'(pin_out));
        cmp("clamp oe", 64'(BST_DRIVE_MASK), 64'(pin_oe));
        cmp("test mode", 64'h1, 64'(mode));
        load_ir(BST_IR_HIGHZ);
        chk_byp("highz path");
        cmp("highz oe", 64'h0, 64'(pin_oe));
        @(posedge clk);
        #1;
        trst_n = 1'b0;
        repeat (4) @(posedge clk);
        cmp("reset pins", 64'(core_oe), 64'(pin_oe));
        #1;
        trst_n = 1'b1;
        go_idle();
    endtask : t_clamp_highz

    task automatic t_codes();
        logic [3:0] codes [3] = '{BST_IR_BYPASS, 4'h5, 4'ha};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            chk_byp("code path");
            cmp("code pins", 64'(core_out), 64'(pin_out));
        end
        cmp("normal mode", 64'h0, 64'(mode));
        load_ir(BST_IR_CLAMP);
        cmp("clamp taken", 64'(BST_DRIVE_MASK), 64'(pin_oe));
        go_idle();
        cmp("tms reset pins", 64'(core_oe), 64'(pin_oe));
    endtask : t_codes

    initial begin
        rst = 1'b1;
        trst_n = 1'b0;
        pin_in = PV;
        core_out = 62'h0f0f0f0f0f0f0f0f;
        core_oe = 62'h1555555555555555;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        trst_n = 1'b1;
        go_idle();
        chk_byp("reset path");
        t_sample();
        t_extest();
        t_clamp_highz();
        t_codes();
        give_verdict();
    end

    initial begin
        #2000000;
        fails++;
        give_verdict();
    end
endmodule : tb_boundary_scan_tap
